/* core/adc_channel_config_test_regs.sv */
// Purpose: Configuration and output test pattern registers of a four-channel converter.
// Assumes: Writes and reads arrive already decoded from the serial control port, one per clock.
// Notes:   Per-channel settings are staged, then made active by the commit bit.
`timescale 1ns/1ns

module adc_channel_config_test_regs (
	input  wire logic                          clk_sys,
	input  wire logic                          nrst,
	input  wire logic                          wr_en,
	input  wire logic                          rd_en,
	input  wire logic [7:0]                    addr,
	input  wire logic [7:0]                    wr_data,
	input  wire logic [11:0]                   user_pattern,
	input  wire cfg_regs_pkg::sample_s [3:0]   conv_in,
	output logic      [7:0]                    rd_data,
	output cfg_regs_pkg::sample_s [3:0]        data_out,
	output logic      [3:0]                    dcs_enable,
	output logic      [2:0]                    chip_mode [3:0],
	output logic                               bit_rate_output_clock_sel,
	output logic                               word_framing_clock_sel
);

	// All state of the block in one packed struct.
	typedef struct packed {
		logic [7:0]                       sel;        // Channel write select mask.
		logic [7:0]                       commit;     // Software commit register.
		cfg_regs_pkg::chan_cfg_s [3:0]    staged;     // Master copies per channel.
		cfg_regs_pkg::chan_cfg_s [3:0]    active;     // Slave copies per channel.
		logic [1:0]                       clk_stage;  // Staged clock channel selects.
		logic [1:0]                       clk_active; // Active clock channel selects.
		logic [22:0]                      pn_long;    // Long pseudorandom generator.
		logic [8:0]                       pn_short;   // Short pseudorandom generator.
		logic                             toggle;     // Alternates every clock.
		logic [7:0]                       rd;         // Read data register.
		cfg_regs_pkg::sample_s [3:0]      out;        // Registered output samples.
	} state_s;

	state_s st_q;  // Registered state.
	state_s st_d;  // Next state.

	// Pattern word for a given test code, before the format adjustment.
	function automatic logic [11:0] pattern_word(input logic [3:0] code, input logic tgl,
		input logic [22:0] pl, input logic [8:0] ps, input logic [11:0] usr,
		input logic [11:0] conv);
		logic [11:0] w;
		w = conv;
		case (code)
			cfg_regs_pkg::TM_MIDSCALE:    w = cfg_regs_pkg::MIDSCALE;
			cfg_regs_pkg::TM_POS_FULL:    w = cfg_regs_pkg::POS_FULL;
			cfg_regs_pkg::TM_NEG_FULL:    w = cfg_regs_pkg::NEG_FULL;
			cfg_regs_pkg::TM_CHECKER:     w = tgl ? cfg_regs_pkg::CHECKER_B
				: cfg_regs_pkg::CHECKER_A;
			cfg_regs_pkg::TM_PN_LONG:     w = pl[11:0];
			cfg_regs_pkg::TM_PN_SHORT:    w = {ps[2:0], ps};
			cfg_regs_pkg::TM_WORD_TOGGLE: w = tgl ? cfg_regs_pkg::ALL_ONES
				: cfg_regs_pkg::ALL_ZEROS;
			cfg_regs_pkg::TM_USER:        w = usr;
			cfg_regs_pkg::TM_BIT_TOGGLE:  w = cfg_regs_pkg::CHECKER_A;
			cfg_regs_pkg::TM_SYNC:        w = cfg_regs_pkg::SYNC_WORD;
			cfg_regs_pkg::TM_ONE_HIGH:    w = cfg_regs_pkg::ONE_HIGH;
			cfg_regs_pkg::TM_MIXED:       w = tgl ? cfg_regs_pkg::MIXED_B
				: cfg_regs_pkg::MIXED_A;
			default:                      w = conv;
		endcase
		return w;
	endfunction

	// Next-state logic: register writes, commit, generators and output selection.
	always_comb
	begin
		logic [11:0] w;
		logic        is_test;
		logic        commit_now;
		w          = '0;
		is_test    = 1'b0;
		commit_now = st_q.commit[cfg_regs_pkg::COMMIT_BIT];
		st_d       = st_q;
		st_d.toggle = ~st_q.toggle;
		// Commit is a one-shot: it clears itself at the same edge at which it copies.
		st_d.commit = '0;
		if (commit_now)
		begin
			st_d.active     = st_q.staged;
			st_d.clk_active = st_q.clk_stage;
		end
		// Writes land only in channels that the select mask names.
		if (wr_en)
		begin
			if (addr == cfg_regs_pkg::ADDR_CHANNEL_WRITE_SELECT)
			begin
				st_d.sel = wr_data & cfg_regs_pkg::SEL_MASK;
			end
			else if (addr == cfg_regs_pkg::ADDR_STAGED_VALUE_TRANSFER)
			begin
				st_d.commit = wr_data & cfg_regs_pkg::COMMIT_MASK;
			end
			else if (addr == cfg_regs_pkg::ADDR_CHIP_OPERATING_MODE ||
				addr == cfg_regs_pkg::ADDR_DUTY_STABILIZER_CTRL ||
				addr == cfg_regs_pkg::ADDR_OUTPUT_TEST_PATTERN_CTRL ||
				addr == cfg_regs_pkg::ADDR_OUTPUT_FORMAT)
			begin
				for (int i = 0; i < cfg_regs_pkg::NUM_CH; i++)
				begin
					if (st_q.sel[cfg_regs_pkg::DATA_CH_LSB + i])
					begin
						if (addr == cfg_regs_pkg::ADDR_CHIP_OPERATING_MODE)
							st_d.staged[i].mode = wr_data & cfg_regs_pkg::MODE_MASK;
						else if (addr == cfg_regs_pkg::ADDR_DUTY_STABILIZER_CTRL)
							st_d.staged[i].dcs = wr_data & cfg_regs_pkg::DCS_MASK;
						else if (addr == cfg_regs_pkg::ADDR_OUTPUT_TEST_PATTERN_CTRL)
							st_d.staged[i].test = wr_data & cfg_regs_pkg::TEST_MASK;
						else
							st_d.staged[i].fmt = wr_data & cfg_regs_pkg::FMT_MASK;
					end
				end
				// Selected clock channels are set to 1 by the write, whatever its data.
				if (st_q.sel[cfg_regs_pkg::BIT_RATE_BIT])
					st_d.clk_stage[1] = 1'b1;
				if (st_q.sel[cfg_regs_pkg::WORD_FRAME_BIT])
					st_d.clk_stage[0] = 1'b1;
			end
		end
		// Per-channel reads return channel 0's staged copy, whatever the select mask.
		st_d.rd = '0;
		if (rd_en)
		begin
			if (addr == cfg_regs_pkg::ADDR_CHANNEL_WRITE_SELECT)
				st_d.rd = st_q.sel;
			else if (addr == cfg_regs_pkg::ADDR_STAGED_VALUE_TRANSFER)
				st_d.rd = st_q.commit;
			else if (addr == cfg_regs_pkg::ADDR_CHIP_OPERATING_MODE)
				st_d.rd = st_q.staged[0].mode;
			else if (addr == cfg_regs_pkg::ADDR_DUTY_STABILIZER_CTRL)
				st_d.rd = st_q.staged[0].dcs;
			else if (addr == cfg_regs_pkg::ADDR_OUTPUT_TEST_PATTERN_CTRL)
				st_d.rd = st_q.staged[0].test;
			else if (addr == cfg_regs_pkg::ADDR_OUTPUT_FORMAT)
				st_d.rd = st_q.staged[0].fmt;
			else
				st_d.rd = '0;
		end
		// Generators restart from seed while any active channel asks it.
		st_d.pn_long  = {st_q.pn_long[21:0], st_q.pn_long[22] ^ st_q.pn_long[17]};
		st_d.pn_short = {st_q.pn_short[7:0], st_q.pn_short[8] ^ st_q.pn_short[4]};
		for (int i = 0; i < cfg_regs_pkg::NUM_CH; i++)
		begin
			if (st_q.active[i].test[cfg_regs_pkg::PN_LONG_RST_BIT])
				st_d.pn_long = cfg_regs_pkg::PN_LONG_SEED;
			if (st_q.active[i].test[cfg_regs_pkg::PN_SHORT_RST_BIT])
				st_d.pn_short = cfg_regs_pkg::PN_SHORT_SEED;
		end
		// Output data: test pattern or converted data per channel.
		for (int i = 0; i < cfg_regs_pkg::NUM_CH; i++)
		begin
			is_test = (st_q.active[i].test[3:0] != cfg_regs_pkg::TM_OFF);
			w = pattern_word(st_q.active[i].test[3:0], st_q.toggle, st_q.pn_long,
				st_q.pn_short, user_pattern, conv_in[i].word);
			// Generated words follow the format; offset binary is the native form.
			if (is_test && st_q.active[i].fmt[1:0] == cfg_regs_pkg::FMT_TWOS)
				w = w ^ cfg_regs_pkg::MSB_FLIP;
			st_d.out[i].word  = w;
			st_d.out[i].valid = is_test ? 1'b1 : conv_in[i].valid;
		end
	end

	// State register with asynchronous reset to the preload values.
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= '0;
			st_q.sel    <= cfg_regs_pkg::RST_CHANNEL_WRITE_SELECT;
			st_q.commit <= cfg_regs_pkg::RST_STAGED_VALUE_TRANSFER;
			for (int i = 0; i < cfg_regs_pkg::NUM_CH; i++)
			begin
				st_q.staged[i] <= {cfg_regs_pkg::RST_CHIP_OPERATING_MODE,
					cfg_regs_pkg::RST_DUTY_STABILIZER_CTRL,
					cfg_regs_pkg::RST_OUTPUT_TEST_PATTERN_CTRL,
					cfg_regs_pkg::RST_OUTPUT_FORMAT};
				st_q.active[i] <= {cfg_regs_pkg::RST_CHIP_OPERATING_MODE,
					cfg_regs_pkg::RST_DUTY_STABILIZER_CTRL,
					cfg_regs_pkg::RST_OUTPUT_TEST_PATTERN_CTRL,
					cfg_regs_pkg::RST_OUTPUT_FORMAT};
			end
			st_q.pn_long  <= cfg_regs_pkg::PN_LONG_SEED;
			st_q.pn_short <= cfg_regs_pkg::PN_SHORT_SEED;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Outputs come straight from the state register.
	always_comb
	begin
		rd_data                   = st_q.rd;
		data_out                  = st_q.out;
		bit_rate_output_clock_sel = st_q.clk_active[1];
		word_framing_clock_sel    = st_q.clk_active[0];
		for (int i = 0; i < cfg_regs_pkg::NUM_CH; i++)
		begin
			dcs_enable[i] = st_q.active[i].dcs[cfg_regs_pkg::DCS_BIT];
			chip_mode[i]  = st_q.active[i].mode[2:0];
		end
	end

endmodule

/* core/cfg_regs_pkg.sv */
// Purpose: Shared constants and carrier types for the converter configuration register block.
// Assumes: Eight-bit registers reached by a simple address/data write and read port.
// Notes:   Widths follow the twelve-bit converter word.
package cfg_regs_pkg;

	// Register addresses.
	localparam logic [7:0] ADDR_CHANNEL_WRITE_SELECT    = 8'h05;
	localparam logic [7:0] ADDR_CHIP_OPERATING_MODE     = 8'h08;
	localparam logic [7:0] ADDR_DUTY_STABILIZER_CTRL    = 8'h09;
	localparam logic [7:0] ADDR_OUTPUT_TEST_PATTERN_CTRL = 8'h0D;
	localparam logic [7:0] ADDR_OUTPUT_FORMAT           = 8'h14;
	localparam logic [7:0] ADDR_STAGED_VALUE_TRANSFER   = 8'hFF;

	// Reset values.
	localparam logic [7:0] RST_CHANNEL_WRITE_SELECT    = 8'h0F;
	localparam logic [7:0] RST_CHIP_OPERATING_MODE     = 8'h00;
	localparam logic [7:0] RST_DUTY_STABILIZER_CTRL    = 8'h01;
	localparam logic [7:0] RST_OUTPUT_TEST_PATTERN_CTRL = 8'h00;
	localparam logic [7:0] RST_OUTPUT_FORMAT           = 8'h00;
	localparam logic [7:0] RST_STAGED_VALUE_TRANSFER   = 8'h00;

	// Field positions and masks.
	localparam int          DATA_CH_LSB   = 0;
	localparam int          DATA_CH_MSB   = 3;
	localparam int          WORD_FRAME_BIT = 4;  // Framing clock channel select bit.
	localparam int          BIT_RATE_BIT   = 5;  // Bit-rate clock channel select bit.
	localparam int          COMMIT_BIT    = 0;
	localparam int          DCS_BIT       = 0;
	localparam int          PN_SHORT_RST_BIT = 4;
	localparam int          PN_LONG_RST_BIT  = 5;
	localparam int          FMT_LSB       = 0;
	localparam logic [7:0]  SEL_MASK      = 8'h3F;
	localparam logic [7:0]  MODE_MASK     = 8'h07;
	localparam logic [7:0]  DCS_MASK      = 8'h01;
	localparam logic [7:0]  TEST_MASK     = 8'h3F;
	localparam logic [7:0]  FMT_MASK      = 8'h03;
	localparam logic [7:0]  COMMIT_MASK   = 8'h01;

	// Converter word.
	localparam int          WORD_W        = 12;
	localparam int          NUM_CH        = 4;
	localparam logic [11:0] MIDSCALE      = 12'h800;
	localparam logic [11:0] POS_FULL      = 12'hFFF;
	localparam logic [11:0] NEG_FULL      = 12'h000;
	localparam logic [11:0] CHECKER_A     = 12'hAAA;
	localparam logic [11:0] CHECKER_B     = 12'h555;
	localparam logic [11:0] ALL_ONES      = 12'hFFF;
	localparam logic [11:0] ALL_ZEROS     = 12'h000;
	localparam logic [11:0] SYNC_WORD     = 12'hFC0;
	localparam logic [11:0] ONE_HIGH      = 12'h800;
	localparam logic [11:0] MIXED_A       = 12'hA33;
	localparam logic [11:0] MIXED_B       = 12'h5CC;
	localparam logic [11:0] MSB_FLIP      = 12'h800;
	localparam logic [1:0]  FMT_TWOS      = 2'h1;

	// Generator seeds and widths.
	localparam logic [22:0] PN_LONG_SEED  = 23'h7FFFFF;
	localparam logic [8:0]  PN_SHORT_SEED = 9'h1FF;

	// Output test modes.
	typedef enum logic [3:0] {
		TM_OFF, TM_MIDSCALE, TM_POS_FULL, TM_NEG_FULL, TM_CHECKER, TM_PN_LONG,
		TM_PN_SHORT, TM_WORD_TOGGLE, TM_USER, TM_BIT_TOGGLE, TM_SYNC, TM_ONE_HIGH,
		TM_MIXED
	} test_mode_e;

	// One channel's output word together with its valid strobe.
	typedef struct packed {
		logic        valid;
		logic [11:0] word;
	} sample_s;

	// Settings of one channel, used for both the staged and the active copies.
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] dcs;
		logic [7:0] test;
		logic [7:0] fmt;
	} chan_cfg_s;

endpackage

/* verif/adc_channel_config_test_regs_assertions.sv */
// Purpose: Port checks for the configuration register block.
// Assumes: Sees only top ports; one clock domain.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ns
module adc_channel_config_test_regs_assertions (
	input logic				clk_sys,
	input logic				nrst,
	input logic				wr_en,
	input logic				rd_en,
	input logic [7:0]			addr,
	input logic [7:0]			wr_data,
	input logic [7:0]			rd_data,
	input cfg_regs_pkg::sample_s [3:0]	conv_in,
	input cfg_regs_pkg::sample_s [3:0]	data_out,
	input logic [3:0]			dcs_enable,
	input logic				bit_rate_output_clock_sel,
	input logic				word_framing_clock_sel
);
	logic		wcommit;	// A write that sets the commit bit.
	logic [5:0]	act;		// Active outputs that only a commit may move.
	assign wcommit = wr_en && addr == 8'hFF && wr_data[0];
	assign act = {dcs_enable, bit_rate_output_clock_sel, word_framing_clock_sel};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Plain format, then a test code, then a commit, two cycles apart.
	sequence s_code(c);
		wr_en && addr == 8'h14 && wr_data[1:0] == 2'h0 ##2
		wr_en && addr == 8'h0D && wr_data == c ##2 wcommit;
	endsequence
	// The first tick is skipped, since the preload may land only at that edge.
	a_reset_vals:
		assert property (disable iff (1'b0) !nrst && $past(!nrst) |-> dcs_enable == 4'hF &&
			!bit_rate_output_clock_sel && !word_framing_clock_sel)
		else $error("outputs not at reset values");
	a_sel_bits:
		assert property (rd_en && addr == 8'h05 |=> rd_data[7:6] == 2'h0)
		else $error("select register unused bits set");
	a_commit_bits:
		assert property (rd_en && addr == 8'hFF |=> rd_data[7:1] == 7'h00)
		else $error("commit register unused bits set");
	a_dcs_bits:
		assert property (rd_en && addr == 8'h09 |=> rd_data[7:1] == 7'h00)
		else $error("stabilizer register unused bits set");
	a_commit_only:
		assert property ($changed(act) |-> $past(wcommit) || $past(wcommit, 2) ||
			$past(wcommit, 3) || $past(wcommit, 4))
		else $error("active setting moved without commit");
	a_normal_pass:
		assert property ($past(nrst) && !data_out[0].valid |-> data_out[0] == $past(conv_in[0]))
		else $error("normal data not passed through");
	a_mid_word:
		assert property (s_code(8'h01) |-> ##[2:5] data_out[0] == 13'h1800)
		else $error("midscale word missing");
	a_pn_restart:
		assert property (s_code(8'h25) |-> ##[2:5] data_out[0].word == 12'hFFF ##1
			data_out[0].word == 12'hFFF)
		else $error("held generator not at seed");
endmodule

/* verif/adc_channel_config_test_regs_tb_top.sv */
// Purpose: Self-checking bench for the configuration register block.
// Assumes: Inputs change at the rising edge, outputs are sampled at the falling edge.
// Notes:   Converter data and the channel mask are random from a fixed seed.
`timescale 1ns/1ns
module adc_channel_config_test_regs_tb_top;
	logic				clk_sys;
	logic				nrst;
	logic				wr_en;
	logic				rd_en;
	logic [7:0]			addr;
	logic [7:0]			wr_data;
	logic [7:0]			rd_data;
	logic [11:0]			user_pattern;
	cfg_regs_pkg::sample_s [3:0]	conv_in;
	cfg_regs_pkg::sample_s [3:0]	data_out;
	cfg_regs_pkg::sample_s [3:0]	prev;	// Values seen one cycle earlier.
	logic [3:0]			dcs_enable;
	logic [2:0]			chip_mode [3:0];
	logic				bit_rate_output_clock_sel;
	logic				word_framing_clock_sel;
	logic [3:0]			m;	// Random channel mask.
	logic [15:0]			tc [16];	// Format byte over test code byte.
	int				failures;
	int				check_count;

	adc_channel_config_test_regs u_dut (.clk_sys, .nrst, .wr_en, .rd_en, .addr, .wr_data,
		.user_pattern, .conv_in, .rd_data, .data_out, .dcs_enable, .chip_mode,
		.bit_rate_output_clock_sel, .word_framing_clock_sel);

	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One write, strobe high for a single cycle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask
	// One read; the answer stands the cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		chk({5'h0, rd_data}, {5'h0, exp});
	endtask
	// Commit, then let the active copy reach the outputs.
	task automatic settle();
		wr(8'hFF, 8'h01);
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	// Select channels, write one staged register, commit.
	task automatic prog(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] d);
		wr(8'h05, sel);
		wr(a, d);
		settle();
	endtask
	// Selected channels show exp; the others pass converter data.
	task automatic look(input logic [3:0] sel, input logic [12:0] exp);
		@(negedge clk_sys);
		prev = conv_in;
		@(negedge clk_sys);
		for (int i = 0; i < 4; i++)
			chk(data_out[i], sel[i] ? exp : prev[i]);
	endtask
	// Expected generated word; toggling codes invert the previous word.
	function automatic logic [11:0] pat(input logic [7:0] c, input logic [11:0] p);
		case (c)
			8'h01, 8'h0B: pat = 12'h800;
			8'h02, 8'h25, 8'h16: pat = 12'hFFF;
			8'h03: pat = 12'h000;
			8'h08: pat = user_pattern;
			8'h09: pat = 12'hAAA;
			8'h0A: pat = 12'hFC0;
			default: pat = ~p;
		endcase
	endfunction
	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Free-running system clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Fresh random converter data every cycle once out of reset.
	always @(posedge clk_sys)
		if (nrst)
			for (int i = 0; i < 4; i++)
				conv_in[i] <= 13'($urandom);
	// Cuts a hang short.
	initial
	begin
		repeat (4000) @(posedge clk_sys);
		failures++;
		results();
	end
	// Main sequence.
	initial
	begin
		{nrst, wr_en, rd_en, addr, wr_data, user_pattern, conv_in} = '0;
		failures = 0;
		check_count = 0;
		void'($urandom(11));
		tc = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008,
			16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h0025, 16'h0016, 16'h0101, 16'h0102};
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		user_pattern <= 12'($urandom);
		rd(8'h05, 8'h0F);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h01);
		rd(8'h0D, 8'h00);
		rd(8'hFF, 8'h00);
		rd(8'h33, 8'h00);
		rd(8'h14, 8'h00);
		chk({7'h0, dcs_enable, bit_rate_output_clock_sel, word_framing_clock_sel}, 13'h03C);
		prog(8'h0F, 8'h0D, 8'h00);
		repeat (6) look(4'h0, 13'h0000);
		m = 4'($urandom_range(15, 1));
		prog({4'h0, m}, 8'h0D, 8'h02);
		look(m, 13'h1FFF);
		rd(8'h0D, {6'h0, m[0], 1'b0});
		rd(8'hFF, 8'h00);
		prog(8'h30, 8'h09, 8'h00);
		chk({7'h0, dcs_enable, bit_rate_output_clock_sel, word_framing_clock_sel}, 13'h03F);
		prog(8'h0F, 8'h09, 8'h00);
		chk({9'h0, dcs_enable}, 13'h0000);
		rd(8'h09, 8'h00);
		prog(8'h0F, 8'h09, 8'h01);
		chk({9'h0, dcs_enable}, 13'h000F);
		prog(8'h0F, 8'h08, 8'hFD);
		for (int i = 0; i < 4; i++)
			chk({10'h0, chip_mode[i]}, 13'h0005);
		rd(8'h08, 8'h05);
		foreach (tc[k])
		begin
			wr(8'h05, 8'h0F);
			wr(8'h14, tc[k][15:8]);
			wr(8'h0D, tc[k][7:0]);
			settle();
			prev = data_out;
			@(negedge clk_sys);
			for (int i = 0; i < 4; i++)
				if (tc[k][7:0] inside {8'h05, 8'h06})
					chk({12'h0, data_out[i].valid}, 13'h0001);
				else
					chk(data_out[i], {1'b1, pat(tc[k][7:0], prev[i].word) ^ {tc[k][8], 11'h0}});
		end
		results();
	end
endmodule

bind adc_channel_config_test_regs adc_channel_config_test_regs_assertions u_chk (.clk_sys,
	.nrst, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .conv_in, .data_out, .dcs_enable,
	.bit_rate_output_clock_sel, .word_framing_clock_sel);
